// ==== usb_tx_fifo_control.v ====
// per-endpoint transmit fifo control: flush, size, iso marking, pointers
// assumes a serial engine that pulses read/ack/nak for the endpoint it names
//
// Behaviour
// R1: flush empties fifo, pointers, byte counts
// R2: flush clears status bits, sets empty flag
// R3: flush bit clears itself when done
// R4: flush keeps the data toggle bit
// R5: firmware flushes only idle or failed endpoints
// R6: size field picks fifo size
// R7: feature off makes codes 10/11 64 bytes; iso codes 10/11 still give 512/1024
// R8: reserved bit 4 reads zero
// R9: iso bit tells engine no handshake
// R10: auto ack moves marker to pointer
// R11: auto nak moves pointer back to marker
// R12: control resets to auto management on
// R13: auto mode ignores manual advance and rewind
// R14: auto bit changes only by firmware write
// R15: firmware keeps auto on for iso
// R16: advance moves marker to pointer, self-clears
// R17: advance needs rewind, auto, flush clear
// R18: rewind moves pointer to marker, self-clears
// R19: rewind needs advance, auto, flush clear
// R20: registers act on selected endpoint copy; here endpoint select and feature stay global
// R21: low count write bumps data-set flags
`timescale 1ns/1ps
`include "usb_tx_fifo_defs.vh"

module usb_tx_fifo_control
(
   // clock and reset
   input  wire                     mclk,
   input  wire                     srst,
   // register port
   input  wire [2:0]               regAddr,
   input  wire [7:0]               regWdata,
   input  wire                     regWr,
   input  wire                     regRd,
   output reg  [7:0]               regRdata_q,
   // serial engine requests
   input  wire [`EP_BITS-1:0]      seEp,
   input  wire                     seRead,
   input  wire                     seAck,
   input  wire                     seNak,
   input  wire                     seError,
   // serial engine answers
   output wire [7:0]               seData_q,
   output reg                      seIso_q,
   output reg  [10:0]              seSize_q,
   output reg                      seEmpty_q
);

   integer i;

   // per-endpoint state
   reg [7:0]             ctl_q     [0:`EP_COUNT-1];
   reg [`PTR_BITS-1:0]   wrPtr_q   [0:`EP_COUNT-1];
   reg [`PTR_BITS-1:0]   rdPtr_q   [0:`EP_COUNT-1];
   reg [`PTR_BITS-1:0]   rdMark_q  [0:`EP_COUNT-1];
   reg [7:0]             cntLow_q  [0:`EP_COUNT-1];
   reg [1:0]             cntHigh_q [0:`EP_COUNT-1];
   reg [1:0]             setFlags_q[0:`EP_COUNT-1];
   reg                   underrun_q[0:`EP_COUNT-1];
   reg                   overflow_q[0:`EP_COUNT-1];
   reg [4:0]             status_q  [0:`EP_COUNT-1];

   // global state
   reg [`EP_BITS-1:0]    epSel_q;
   reg                   feature_q;
   reg                   flushPend_q;
   reg [`EP_BITS-1:0]    flushEp_q;

   // fifo size in bytes from code, iso mark and feature enable
   function [10:0] sizeOf;
      input [1:0] code;
      input       iso;
      input       feat;
      begin
         if (iso)
         begin
            case (code)
               2'h0:    sizeOf = 11'h040;
               2'h1:    sizeOf = 11'h100;
               2'h2:    sizeOf = 11'h200;
               default: sizeOf = 11'h400;
            endcase
         end
         else
         begin
            case (code)
               2'h0:    sizeOf = 11'h010;
               2'h1:    sizeOf = 11'h040;
               2'h2:    sizeOf = feat ? 11'h008 : 11'h040; // see R7
               default: sizeOf = feat ? 11'h020 : 11'h040; // see R7
            endcase
         end
      end
   endfunction

   // pointer step that wraps at the selected size
   function [`PTR_BITS-1:0] stepPtr;
      input [`PTR_BITS-1:0] ptr;
      input [10:0]          size;
      reg   [10:0]          nxt;
      begin
         nxt = {1'b0, ptr} + 11'h001;
         if (nxt >= size)
         begin
            stepPtr = {`PTR_BITS{1'b0}};
         end
         else
         begin
            stepPtr = nxt[`PTR_BITS-1:0];
         end
      end
   endfunction

   // data-set flags after a set is validated
   function [1:0] addSet;
      input [1:0] f;
      begin
         case (f)
            2'h0:    addSet = 2'h1;
            default: addSet = 2'h3;
         endcase
      end
   endfunction

   // data-set flags after the oldest set is discarded
   function [1:0] dropSet;
      input [1:0] f;
      begin
         case (f)
            2'h3:    dropSet = 2'h2;
            default: dropSet = 2'h0;
         endcase
      end
   endfunction

   // current sizes, used by the firmware write path and the engine path
   wire [7:0]  selCtl  = ctl_q[epSel_q];
   wire [7:0]  engCtl  = ctl_q[seEp];
   wire [10:0] selSize = sizeOf(selCtl[`CTL_SIZE_HI:`CTL_SIZE_LO], selCtl[`CTL_ISO], feature_q);
   wire [10:0] engSize = sizeOf(engCtl[`CTL_SIZE_HI:`CTL_SIZE_LO], engCtl[`CTL_ISO], feature_q);

   wire dataWr    = regWr && (regAddr == `OFS_TX_DATA);
   wire engEmpty  = (setFlags_q[seEp] == 2'h0);
   wire engRead   = seRead && !engEmpty;

   // storage; writes land at the selected endpoint's write pointer
   tx_fifo_ram u_ram
   (
      .mclk     (mclk),
      .wrEn     (dataWr),
      .wrAddr   ({epSel_q, wrPtr_q[epSel_q]}),
      .wrData   (regWdata),
      .rdEn     (engRead),
      .rdAddr   ({seEp, rdPtr_q[seEp]}),
      .rdData_q (seData_q)
   );

   always @(posedge mclk)
   begin
      if (srst)
      begin
         for (i = 0; i < `EP_COUNT; i = i + 1)
         begin
            ctl_q[i]      <= `CTL_RESET; // see R12
            wrPtr_q[i]    <= {`PTR_BITS{1'b0}};
            rdPtr_q[i]    <= {`PTR_BITS{1'b0}};
            rdMark_q[i]   <= {`PTR_BITS{1'b0}};
            cntLow_q[i]   <= 8'h00;
            cntHigh_q[i]  <= 2'h0;
            setFlags_q[i] <= `FLAGS_RESET;
            underrun_q[i] <= 1'b0;
            overflow_q[i] <= 1'b0;
            status_q[i]   <= 5'h00;
         end
         epSel_q     <= {`EP_BITS{1'b0}};
         feature_q   <= `FEATURE_RESET;
         flushPend_q <= 1'b0;
         flushEp_q   <= {`EP_BITS{1'b0}};
      end
      else
      begin
         // firmware writes land in the selected endpoint's copy, except endpoint select and feature, which are global
         if (regWr)
         begin
            case (regAddr) // see R20
               `OFS_TX_DATA:
               begin
                  if (setFlags_q[epSel_q] == 2'h3)
                  begin
                     overflow_q[epSel_q] <= 1'b1;
                  end
                  wrPtr_q[epSel_q] <= stepPtr(wrPtr_q[epSel_q], selSize);
               end
               `OFS_COUNT_LOW:
               begin
                  cntLow_q[epSel_q]   <= regWdata;
                  setFlags_q[epSel_q] <= addSet(setFlags_q[epSel_q]); // see R21
               end
               `OFS_COUNT_HIGH:
               begin
                  cntHigh_q[epSel_q] <= regWdata[1:0];
               end
               `OFS_TX_CONTROL:
               begin
                  // reserved bit is never stored; auto bit only moves here
                  ctl_q[epSel_q] <= {regWdata[7:5], 1'b0, regWdata[3:0]}; // see R8, R14
                  if (regWdata[`CTL_FLUSH])
                  begin
                     flushPend_q <= 1'b1;
                     flushEp_q   <= epSel_q;
                  end
               end
               `OFS_TX_FLAGS:
               begin
                  overflow_q[epSel_q] <= regWdata[0];
               end
               `OFS_ENDPOINT_SEL:
               begin
                  epSel_q <= regWdata[`EP_BITS-1:0];
               end
               `OFS_FEATURE:
               begin
                  feature_q <= regWdata[0];
               end
               default:
               begin
                  feature_q <= feature_q;
               end
            endcase
         end

         // manual controls; both set at once means neither acts
         for (i = 0; i < `EP_COUNT; i = i + 1)
         begin
            if (!ctl_q[i][`CTL_AUTO] && !ctl_q[i][`CTL_FLUSH]) // see R13
            begin
               if (ctl_q[i][`CTL_ADVANCE] && !ctl_q[i][`CTL_REWIND]) // see R17
               begin
                  rdMark_q[i]           <= rdPtr_q[i]; // see R16
                  setFlags_q[i]         <= dropSet(setFlags_q[i]);
                  ctl_q[i][`CTL_ADVANCE] <= 1'b0; // see R16
               end
               if (ctl_q[i][`CTL_REWIND] && !ctl_q[i][`CTL_ADVANCE]) // see R19
               begin
                  rdPtr_q[i]            <= rdMark_q[i]; // see R18
                  ctl_q[i][`CTL_REWIND] <= 1'b0; // see R18
               end
            end
         end

         // serial engine reads a byte; empty fifo flags an underrun
         if (seRead)
         begin
            if (engEmpty)
            begin
               underrun_q[seEp] <= 1'b1;
            end
            else
            begin
               rdPtr_q[seEp] <= stepPtr(rdPtr_q[seEp], engSize);
            end
         end

         // handshake outcomes
         if (seAck)
         begin
            status_q[seEp][`STAT_ACKED]  <= 1'b1;
            status_q[seEp][`STAT_ERROR]  <= 1'b0;
            status_q[seEp][`STAT_TOGGLE] <= !status_q[seEp][`STAT_TOGGLE];
            if (engCtl[`CTL_AUTO])
            begin
               rdMark_q[seEp]   <= rdPtr_q[seEp]; // see R10
               setFlags_q[seEp] <= dropSet(setFlags_q[seEp]);
            end
         end
         else if (seNak && engCtl[`CTL_AUTO])
         begin
            rdPtr_q[seEp] <= rdMark_q[seEp]; // see R11
         end
         if (seError)
         begin
            status_q[seEp][`STAT_ERROR] <= 1'b1;
            status_q[seEp][`STAT_ACKED] <= 1'b0;
         end

         // flush runs one cycle after the request and wins over everything
         if (flushPend_q)
         begin
            flushPend_q                      <= 1'b0;
            wrPtr_q[flushEp_q]               <= {`PTR_BITS{1'b0}}; // see R1
            rdPtr_q[flushEp_q]               <= {`PTR_BITS{1'b0}}; // see R1
            rdMark_q[flushEp_q]              <= {`PTR_BITS{1'b0}}; // see R1
            cntLow_q[flushEp_q]              <= 8'h00; // see R1
            cntHigh_q[flushEp_q]             <= 2'h0; // see R1
            setFlags_q[flushEp_q]            <= 2'h0; // see R2
            underrun_q[flushEp_q]            <= 1'b0; // see R2
            overflow_q[flushEp_q]            <= 1'b0; // see R2
            // toggle bit is deliberately left alone
            status_q[flushEp_q][3:0]         <= 4'h0; // see R2, R4
            ctl_q[flushEp_q][`CTL_FLUSH]     <= 1'b0; // see R3
         end
      end
   end

   // register reads, data in the cycle after the strobe
   always @(posedge mclk)
   begin
      if (srst)
      begin
         regRdata_q <= 8'h00;
      end
      else if (regRd)
      begin
         case (regAddr)
            `OFS_COUNT_LOW:    regRdata_q <= cntLow_q[epSel_q];
            `OFS_COUNT_HIGH:   regRdata_q <= {6'h00, cntHigh_q[epSel_q]};
            `OFS_TX_CONTROL:   regRdata_q <= selCtl & 8'hEF; // see R8
            `OFS_TX_FLAGS:     regRdata_q <= {setFlags_q[epSel_q], 2'h0,
                                              setFlags_q[epSel_q] == 2'h0,
                                              setFlags_q[epSel_q] == 2'h3,
                                              underrun_q[epSel_q], overflow_q[epSel_q]};
            `OFS_TX_STATUS:    regRdata_q <= {3'h0, status_q[epSel_q]};
            `OFS_ENDPOINT_SEL: regRdata_q <= {{(8-`EP_BITS){1'b0}}, epSel_q};
            `OFS_FEATURE:      regRdata_q <= {7'h00, feature_q};
            default:           regRdata_q <= 8'h00;
         endcase
      end
      else
      begin
         regRdata_q <= 8'h00;
      end
   end

   // engine-facing view of the named endpoint, one cycle behind seEp
   always @(posedge mclk)
   begin
      if (srst)
      begin
         seIso_q   <= 1'b0;
         seSize_q  <= 11'h000;
         seEmpty_q <= 1'b1;
      end
      else
      begin
         seIso_q   <= engCtl[`CTL_ISO]; // see R9
         seSize_q  <= engSize; // see R6
         seEmpty_q <= engEmpty;
      end
   end

endmodule

// ==== usb_tx_fifo_defs.vh ====
// constants for the per-endpoint transmit fifo control block
// assumes an 8-bit register port with a 3-bit address, four endpoints
`ifndef USB_TX_FIFO_DEFS_VH
`define USB_TX_FIFO_DEFS_VH

// register offsets
`define OFS_TX_DATA        3'h0
`define OFS_COUNT_LOW      3'h1
`define OFS_COUNT_HIGH     3'h2
`define OFS_TX_CONTROL     3'h3
`define OFS_TX_FLAGS       3'h4
`define OFS_TX_STATUS      3'h5
`define OFS_ENDPOINT_SEL   3'h6
`define OFS_FEATURE        3'h7

// control register fields
`define CTL_FLUSH          7
`define CTL_SIZE_HI        6
`define CTL_SIZE_LO        5
`define CTL_RESERVED       4
`define CTL_ISO            3
`define CTL_AUTO           2
`define CTL_ADVANCE        1
`define CTL_REWIND         0
`define CTL_RESET          8'h04

// status register fields
`define STAT_FLUSHED       0
`define STAT_VOIDED        1
`define STAT_ERROR         2
`define STAT_ACKED         3
`define STAT_TOGGLE        4

// reset values
`define FLAGS_RESET        2'h0
`define FEATURE_RESET      1'h0

// endpoint storage geometry
`define EP_COUNT           4
`define EP_BITS            2
`define PTR_BITS           10
`define RAM_ABITS          12
`endif

// ==== tx_fifo_ram.v ====
// byte storage for all endpoint transmit fifos, one 1024-byte region each
// assumes one writer (firmware port) and one reader (serial engine)
`timescale 1ns/1ps
`include "usb_tx_fifo_defs.vh"

module tx_fifo_ram
(
   // clock
   input  wire                     mclk,
   // write side
   input  wire                     wrEn,
   input  wire [`RAM_ABITS-1:0]    wrAddr,
   input  wire [7:0]               wrData,
   // read side, data one cycle later from a register
   input  wire                     rdEn,
   input  wire [`RAM_ABITS-1:0]    rdAddr,
   output reg  [7:0]               rdData_q
);

   reg [7:0] mem [0:(1<<`RAM_ABITS)-1];

   always @(posedge mclk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      if (rdEn)
      begin
         rdData_q <= mem[rdAddr];
      end
   end

endmodule

// ==== usb_tx_fifo_control_assertions.sv ====
// checker for the transmit fifo control block, bound to its top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "usb_tx_fifo_defs.vh"
module usb_tx_fifo_control_assertions
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   // register port
   input wire logic [2:0]  regAddr,
   input wire logic [7:0]  regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [7:0]  regRdata_q,
   // serial engine
   input wire logic [1:0]  seEp,
   input wire logic        seRead,
   input wire logic        seAck,
   input wire logic        seNak,
   input wire logic        seError,
   input wire logic [7:0]  seData_q,
   input wire logic        seIso_q,
   input wire logic [10:0] seSize_q,
   input wire logic        seEmpty_q
);
   logic [1:0] epSel_q;
   logic       featEn_q;
   logic [3:0] autoSh_q;
   wire        autoCur = autoSh_q[epSel_q];
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // shadows of firmware writes only, so any change by the block itself shows up
   always @(posedge mclk)
   begin
      if (srst)
      begin
         epSel_q <= 2'h0;
         featEn_q <= 1'b0;
         autoSh_q <= 4'hF;
      end
      else if (regWr)
      begin
         if (regAddr == 3'h6) epSel_q <= regWdata[1:0];
         if (regAddr == 3'h7) featEn_q <= regWdata[0];
         if (regAddr == 3'h3) autoSh_q[epSel_q] <= regWdata[2];
      end
   end
   a_read_idle: assert property (!regRd |=> regRdata_q == 8'h00)
      else $error("read data not zero without a read");
   a_reserved_zero: assert property (regRd && regAddr == 3'h3 |=> !regRdata_q[4])
      else $error("reserved control bit read as one");
   a_auto_kept: assert property (regRd && regAddr == 3'h3
      |=> regRdata_q[2] == $past(autoCur))
      else $error("auto management bit changed without a write");
   a_flush_done: assert property (regWr && regAddr == 3'h3 && regWdata[7]
      ##1 !regWr ##1 (!regWr && regRd && regAddr == 3'h3) |=> !regRdata_q[7])
      else $error("flush bit still set");
   a_flush_empty: assert property (regWr && regAddr == 3'h3 && regWdata[7]
      && seEp == epSel_q ##1 (seEp == epSel_q) [*3] |-> seEmpty_q)
      else $error("fifo not empty after flush");
   a_iso_size: assert property (!$past(srst) && seIso_q
      |-> seSize_q inside {64, 256, 512, 1024})
      else $error("bad isochronous size");
   a_plain_size: assert property (!$past(srst) && !seIso_q
      |-> seSize_q inside {8, 16, 32, 64})
      else $error("bad nonisochronous size");
   a_feat_off: assert property (!$past(srst) && !seIso_q && !featEn_q
      && !$past(featEn_q) && !$past(featEn_q, 2) |-> seSize_q inside {16, 64})
      else $error("small size while feature off");
endmodule
bind usb_tx_fifo_control usb_tx_fifo_control_assertions chk_u (.mclk, .srst, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata_q, .seEp, .seRead, .seAck, .seNak, .seError,
   .seData_q, .seIso_q, .seSize_q, .seEmpty_q);

// ==== usb_host_model.sv ====
// serial engine side model: picks an endpoint, reads bytes, reports handshakes
// assumes the block answers a byte read in the next cycle
`timescale 1ns/1ps
module usb_host_model
(
   // clock
   input  wire logic       mclk,
   // requests
   output logic [1:0]      seEp,
   output logic            seRead,
   output logic            seAck,
   output logic            seNak,
   output logic            seError,
   // answer
   input  wire logic [7:0] seData_q
);
   initial
   begin
      seEp = 2'h0;
      {seRead, seAck, seNak, seError} = 4'h0;
   end
   // kind 0 read, 1 ack, 2 nak, 3 error; gap models a slow host
   task automatic pulse(input int kind, input int gap);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      {seRead, seAck, seNak, seError} <= 4'h1 << (3 - kind);
      @(posedge mclk);
      {seRead, seAck, seNak, seError} <= 4'h0;
   endtask
   task automatic get(output logic [7:0] b, input int gap);
      pulse(0, gap);
      #1 b = seData_q;
   endtask
   task automatic sel(input logic [1:0] ep);
      @(posedge mclk);
      seEp <= ep;
   endtask
endmodule

// ==== usb_tx_fifo_control_tb_top.sv ====
// self-checking bench: register port tasks plus the serial engine model
// assumes the register read answer stands only in the cycle after the strobe
`timescale 1ns/1ps
`include "usb_tx_fifo_defs.vh"
module usb_tx_fifo_control_tb_top;
   logic mclk, srst, regWr, regRd, seRead, seAck, seNak, seError, seIso_q, seEmpty_q;
   logic [2:0]  regAddr;
   logic [7:0]  regWdata, regRdata_q, seData_q;
   logic [1:0]  seEp;
   logic [10:0] seSize_q;
   int          miscompares = 0;
   int          check_count = 0;
   usb_tx_fifo_control dut_u (.mclk, .srst, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata_q, .seEp, .seRead, .seAck, .seNak, .seError, .seData_q, .seIso_q,
      .seSize_q, .seEmpty_q);
   usb_host_model host_u (.mclk, .seEp, .seRead, .seAck, .seNak, .seError, .seData_q);
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic finish_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [10:0] g, input logic [10:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk({3'h0, regRdata_q}, {3'h0, e});
   endtask
   task automatic rx(input logic [7:0] e, input int gap);
      logic [7:0] b;
      host_u.get(b, gap);
      chk({3'h0, b}, {3'h0, e});
   endtask
   task automatic load(input int n, input logic [7:0] base);
      for (int k = 0; k < n; k++)
         wr(`OFS_TX_DATA, base + k[7:0]);
      wr(`OFS_COUNT_HIGH, 8'h00);
      wr(`OFS_COUNT_LOW, n[7:0]);
   endtask
   function automatic logic [10:0] sz(input logic [1:0] c, input logic i, input logic f);
      if (i)
         sz = (c == 0) ? 11'h040 : (c == 1) ? 11'h100 : (c == 2) ? 11'h200 : 11'h400;
      else
         sz = (c == 0) ? 11'h010 : (c == 1 || !f) ? 11'h040 : (c == 2) ? 11'h008 : 11'h020;
   endfunction
   // a hang ends the run as a failure
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      finish_test;
   end
   initial
   begin
      int f, i, c;
      {srst, regWr, regRd, regAddr, regWdata} = {1'b1, 13'h0};
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      for (i = 0; i < 4; i++)
      begin
         wr(`OFS_ENDPOINT_SEL, i[7:0]);
         rd(`OFS_TX_CONTROL, `CTL_RESET);
         rd(`OFS_TX_FLAGS, 8'h08);
      end
      rd(`OFS_TX_DATA, 8'h00);
      host_u.sel(2'h3);
      wr(`OFS_TX_CONTROL, 8'h1C);
      rd(`OFS_TX_CONTROL, 8'h0C);
      for (f = 0; f < 2; f++)
      begin
         wr(`OFS_FEATURE, f[7:0]);
         for (i = 0; i < 2; i++)
            for (c = 0; c < 4; c++)
            begin
               wr(`OFS_TX_CONTROL, {1'b0, c[1:0], 1'b0, i[0], 3'h4});
               repeat (2) @(posedge mclk);
               #1 chk(seSize_q, sz(c[1:0], i[0], f[0]));
               chk({10'h0, seIso_q}, {10'h0, i[0]});
            end
      end
      wr(`OFS_ENDPOINT_SEL, 8'h00);
      host_u.sel(2'h0);
      rd(`OFS_TX_CONTROL, 8'h04);
      load(3, 8'hA0);
      rd(`OFS_TX_FLAGS, 8'h40);
      rx(8'hA0, 0);
      rx(8'hA1, 2);
      host_u.pulse(2, 0);
      rx(8'hA0, 0);
      rx(8'hA1, 0);
      rx(8'hA2, 1);
      host_u.pulse(1, 1);
      rd(`OFS_TX_FLAGS, 8'h08);
      rd(`OFS_TX_STATUS, 8'h18);
      // read of an empty fifo sets underrun, so the flush below has flags to clear
      host_u.pulse(0, 0);
      rd(`OFS_TX_FLAGS, 8'h0A);
      load(1, 8'hD0);
      host_u.pulse(3, 0);
      rd(`OFS_TX_STATUS, 8'h14);
      wr(`OFS_TX_FLAGS, 8'h01);
      wr(`OFS_COUNT_HIGH, 8'h02);
      rd(`OFS_TX_FLAGS, 8'h43);
      rd(`OFS_COUNT_HIGH, 8'h02);
      wr(`OFS_TX_CONTROL, 8'h84);
      rd(`OFS_TX_CONTROL, 8'h04);
      rd(`OFS_TX_FLAGS, 8'h08);
      rd(`OFS_TX_STATUS, 8'h10);
      rd(`OFS_COUNT_LOW, 8'h00);
      rd(`OFS_COUNT_HIGH, 8'h00);
      chk({10'h0, seEmpty_q}, 11'h1);
      wr(`OFS_TX_CONTROL, 8'h00);
      load(2, 8'hB0);
      rx(8'hB0, 0);
      rx(8'hB1, 0);
      wr(`OFS_TX_CONTROL, 8'h01);
      repeat (2) @(posedge mclk);
      rd(`OFS_TX_CONTROL, 8'h00);
      rx(8'hB0, 0);
      wr(`OFS_TX_CONTROL, 8'h03);
      repeat (2) @(posedge mclk);
      rd(`OFS_TX_CONTROL, 8'h03);
      wr(`OFS_TX_CONTROL, 8'h02);
      repeat (2) @(posedge mclk);
      rd(`OFS_TX_CONTROL, 8'h00);
      rd(`OFS_TX_FLAGS, 8'h08);
      wr(`OFS_TX_CONTROL, 8'h84);
      load(2, 8'hC0);
      rx(8'hC0, 0);
      wr(`OFS_TX_CONTROL, 8'h05);
      repeat (2) @(posedge mclk);
      rx(8'hC1, 0);
      finish_test;
   end
endmodule
